// file: rtl/apcm_pkg.sv
package apcm_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam logic [6:0] TARGET_ADDR_DEFAULT = 7'h4c;
  localparam logic [7:0] ROLE_CFG_ADDR = 8'h13;
  localparam logic [7:0] RATE_CFG_ADDR = 8'h14;
  localparam logic [7:0] MON_STS_ADDR = 8'h15;
  localparam logic [7:0] CLOCK_SOURCE_CONFIG_ADDR = 8'h16;
  localparam logic [7:0] ROLE_CFG_RESET = 8'h02;
  localparam logic [7:0] RATE_CFG_RESET = 8'h48;
  localparam logic [7:0] MON_STS_RESET = 8'hff;
  localparam logic [7:0] CLOCK_SOURCE_CONFIG_RESET = 8'h10;
  localparam logic [3:0] CODE_INVALID = 4'hf;
  localparam logic [3:0] RATE_CODE_MAX = 4'h8;
  localparam logic [3:0] RATIO_CODE_MAX = 4'hc;
  localparam int MON_TIMEOUT_CYCLES = 4096;
  localparam int PERIOD_TOL_SHIFT = 5;
  localparam int BCLK_HALF_CYCLES = 1;
  localparam logic [11:0] RESET_FRAME_RATIO = 12'h100;

  localparam int FRAME_RATIO [0:12] = '{16, 24, 32, 48, 64, 96, 128, 192, 256, 384, 512,
    1024, 2048};
  localparam int RATE48_HZ [0:8] = '{8000, 16000, 24000, 32000, 48000, 96000, 192000,
    384000, 768000};
  localparam int RATE44_HZ [0:8] = '{7350, 14700, 22050, 29400, 44100, 88200, 176400,
    352800, 705600};
  localparam int REF_KHZ [0:7] = '{12000, 12288, 13000, 16000, 19200, 19680, 24000, 24576};
  localparam int REF_RATIO [0:7] = '{64, 256, 384, 512, 768, 1024, 1536, 2304};

  typedef struct packed {
    logic controller;
    logic customClocks;
    logic autoPllOff;
    logic gate;
    logic family44;
    logic [2:0] refCode;
  } apcm_role_cfg_s;

  typedef struct packed {
    logic [3:0] rate;
    logic [3:0] ratio;
  } apcm_rate_cfg_s;

  typedef struct packed {
    logic rootFromRef;
    logic refMultiple;
    logic [2:0] refRatio;
    logic spare2;
    logic invertForFrame;
    logic spare0;
  } apcm_clock_source_config_s;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_REG = 7'h04,
    ST_WDATA = 7'h08,
    ST_RDATA = 7'h10,
    ST_ACK = 7'h20,
    ST_MACK = 7'h40
  } apcm_target_st_e;
endpackage : apcm_pkg

// file: rtl/apcm_clock_gen.sv
`timescale 1ns/1ps
module apcm_clock_gen #(
  parameter int HALF_CYCLES = apcm_pkg::BCLK_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic run,
  input wire logic gate,
  input wire logic invert,
  input wire logic [11:0] ratio,
  output logic bclkOut,
  output logic frameOut
);
  import apcm_pkg::*;

  logic [11:0] divCnt_reg;
  logic [11:0] bitIdx_reg;
  logic toggle;
  logic frameEdge;

  assign toggle = (divCnt_reg == 12'(HALF_CYCLES - 1));
  // Frame logic may follow the inverted bit clock; the pin itself never inverts
  assign frameEdge = toggle & (invert ? ~bclkOut : bclkOut);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      divCnt_reg <= 12'h000;
      bitIdx_reg <= 12'h000;
      bclkOut <= 1'b0;
      frameOut <= 1'b0;
    end else if (ce) begin
      if (!run || gate) begin
        divCnt_reg <= 12'h000;
        bitIdx_reg <= 12'h000;
        bclkOut <= 1'b0;
        frameOut <= 1'b0;
      end else begin
        divCnt_reg <= toggle ? 12'h000 : divCnt_reg + 12'h001;
        if (toggle) begin
          bclkOut <= ~bclkOut;
        end
        if (frameEdge) begin
          bitIdx_reg <= (bitIdx_reg == ratio - 12'h001) ? 12'h000 : bitIdx_reg + 12'h001;
          frameOut <= (bitIdx_reg == ratio - 12'h001);
        end
      end
    end
  end
endmodule : apcm_clock_gen

// file: rtl/apcm_rate_monitor.sv
`timescale 1ns/1ps
module apcm_rate_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic bclk,
  input wire logic frame,
  output apcm_pkg::apcm_rate_cfg_s detected
);
  import apcm_pkg::*;

  logic bclkPrev_reg;
  logic framePrev_reg;
  logic seen_reg;
  logic [11:0] bclkCnt_reg;
  logic [12:0] cycCnt_reg;
  logic bclkRise;
  logic frameRise;
  logic [3:0] rateLook;
  logic [3:0] ratioLook;

  assign bclkRise = bclk & ~bclkPrev_reg;
  assign frameRise = frame & ~framePrev_reg;

  // Last match wins, so the 48 kHz family is preferred where windows touch
  always_comb begin
    int per;
    int tol;
    per = int'(cycCnt_reg);
    tol = 0;
    rateLook = CODE_INVALID;
    ratioLook = CODE_INVALID;
    for (int i = 12; i >= 0; i--) begin
      if (bclkCnt_reg == 12'(FRAME_RATIO[i])) ratioLook = 4'(i);
    end
    for (int i = 8; i >= 0; i--) begin
      tol = ((CLK_HZ / RATE44_HZ[i]) >> PERIOD_TOL_SHIFT) + 1;
      if (per >= CLK_HZ / RATE44_HZ[i] - tol && per <= CLK_HZ / RATE44_HZ[i] + tol) begin
        rateLook = 4'(i);
      end
      tol = ((CLK_HZ / RATE48_HZ[i]) >> PERIOD_TOL_SHIFT) + 1;
      if (per >= CLK_HZ / RATE48_HZ[i] - tol && per <= CLK_HZ / RATE48_HZ[i] + tol) begin
        rateLook = 4'(i);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bclkPrev_reg <= 1'b0;
      framePrev_reg <= 1'b0;
      seen_reg <= 1'b0;
      bclkCnt_reg <= 12'h000;
      cycCnt_reg <= 13'h0000;
      detected <= MON_STS_RESET;
    end else if (ce) begin
      bclkPrev_reg <= bclk;
      framePrev_reg <= frame;
      if (frameRise) begin
        seen_reg <= 1'b1;
        if (seen_reg) begin
          detected <= '{rate: rateLook, ratio: ratioLook};
        end
        bclkCnt_reg <= bclkRise ? 12'h001 : 12'h000;
        cycCnt_reg <= 13'h0001;
      end else if (cycCnt_reg == 13'(MON_TIMEOUT_CYCLES)) begin
        // Clocks stopped: fall back to the invalid codes
        seen_reg <= 1'b0;
        detected <= MON_STS_RESET;
      end else begin
        cycCnt_reg <= cycCnt_reg + 13'h0001;
        if (bclkRise && bclkCnt_reg != 12'hfff) bclkCnt_reg <= bclkCnt_reg + 12'h001;
      end
    end
  end
endmodule : apcm_rate_monitor

// file: rtl/apcm_top.sv
`timescale 1ns/1ps
// Function
// - Role 0 takes bit clock and frame sync in; role 1 drives both out.
// - Automatic setting 0 derives dividers; 1 uses custom programmed values.
// - Under automatic setting, PLL runs when its disable bit is 0.
// - Gate bit 1 in controller role holds outgoing clocks off.
// - Rate family bit selects 48 kHz family at 0, 44.1 kHz family at 1, in controller role only.
// - Three-bit code gives reference frequency, 12 to 24.576 MHz, reset 010b.
// - Programmed rate codes 0 to 8 valid; 9 to 15 reserved.
// - Programmed ratio codes 0 to 12 give 16 to 2048; rest reserved.
// - Target role with automatic setting ignores programmed rate and ratio.
// - Detected rate status uses same codes; 15 means invalid.
// - Detected ratio status codes 0 to 12; 15 means invalid.
// - Monitor status reads all ones after reset.
// - Programmed rate resets to code 4, ratio to code 8.
// - Clock source register holds root source, mode, ratio and invert bits.
// - PLL-off target root clock from bit clock at 0, reference at 1.
// - Mode bit 1 states reference as frame sync multiple.
// - Reference ratio codes 0 to 7 give 64 to 2304.
// - Inversion bit inverts bit clock only for frame sync generation.
module apcm_top #(
  parameter logic [6:0] TARGET_ADDR = apcm_pkg::TARGET_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic bitClockIn,
  output logic bitClockOut,
  output logic bitClockOe,
  input wire logic frameSyncIn,
  output logic frameSyncOut,
  output logic frameSyncOe,
  output logic customDividers,
  output logic pllRunning,
  output logic rootFromReference,
  output logic programmedInUse,
  output logic family44,
  output logic [3:0] dividerRate,
  output logic [3:0] dividerRatio,
  output logic refIsMultiple,
  output logic [15:0] refFreqKhz,
  output logic [11:0] refRatioValue
);
  import apcm_pkg::*;

  apcm_role_cfg_s roleCfg_reg;
  apcm_rate_cfg_s rateCfg_reg;
  apcm_clock_source_config_s clkSrc_reg;
  apcm_rate_cfg_s detected;
  apcm_target_st_e state_reg;
  apcm_target_st_e ackTo_reg;
  logic sclPrev_reg;
  logic sdaPrev_reg;
  logic [7:0] shift_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] ptr_reg;
  logic [11:0] activeRatio_reg;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic byteDone;
  logic wrStb;
  logic [7:0] readData;
  logic monBclk;
  logic monFrame;

  assign sclRise = scl & ~sclPrev_reg;
  assign sclFall = ~scl & sclPrev_reg;
  assign startSeen = scl & sclPrev_reg & sdaPrev_reg & ~sdaIn;
  assign stopSeen = scl & sclPrev_reg & ~sdaPrev_reg & sdaIn;
  assign byteDone = sclFall && (bitCnt_reg == 4'h8);
  assign wrStb = (state_reg == ST_WDATA) && byteDone;

  always_comb begin
    unique case (ptr_reg)
      ROLE_CFG_ADDR: readData = roleCfg_reg;
      RATE_CFG_ADDR: readData = rateCfg_reg;
      MON_STS_ADDR: readData = detected;
      CLOCK_SOURCE_CONFIG_ADDR: readData = clkSrc_reg;
      default: readData = 8'h00;
    endcase
  end

  // Serial control target: address byte, pointer byte, then data with auto-increment
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
      state_reg <= ST_IDLE;
      ackTo_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      bitCnt_reg <= 4'h0;
      ptr_reg <= 8'h00;
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
    end else if (ce) begin
      sclPrev_reg <= scl;
      sdaPrev_reg <= sdaIn;
      if (startSeen) begin
        state_reg <= ST_ADDR;
        bitCnt_reg <= 4'h0;
        sdaOe <= 1'b0;
      end else if (stopSeen) begin
        state_reg <= ST_IDLE;
        sdaOe <= 1'b0;
      end else begin
        unique case (state_reg)
          ST_IDLE: begin
          end
          ST_ADDR, ST_REG, ST_WDATA: begin
            if (sclRise) begin
              shift_reg <= {shift_reg[6:0], sdaIn};
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (byteDone) begin
              bitCnt_reg <= 4'h0;
              sdaOe <= 1'b1;
              state_reg <= ST_ACK;
              if (state_reg == ST_ADDR) begin
                ackTo_reg <= shift_reg[0] ? ST_RDATA : ST_REG;
                if (shift_reg[7:1] != TARGET_ADDR) begin
                  sdaOe <= 1'b0;
                  state_reg <= ST_IDLE;
                end
              end else begin
                ackTo_reg <= ST_WDATA;
                ptr_reg <= (state_reg == ST_REG) ? shift_reg : ptr_reg + 8'h01;
              end
            end
          end
          ST_ACK: begin
            if (sclFall) begin
              state_reg <= ackTo_reg;
              sdaOe <= 1'b0;
              if (ackTo_reg == ST_RDATA) begin
                // First data bit goes out on the same falling edge
                sdaOe <= ~readData[7];
                shift_reg <= {readData[6:0], 1'b0};
                bitCnt_reg <= 4'h1;
              end
            end
          end
          ST_RDATA: begin
            if (byteDone) begin
              sdaOe <= 1'b0;
              state_reg <= ST_MACK;
              ptr_reg <= ptr_reg + 8'h01;
            end else if (sclFall) begin
              sdaOe <= ~shift_reg[7];
              shift_reg <= {shift_reg[6:0], 1'b0};
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end
          end
          ST_MACK: begin
            if (sclRise) begin
              state_reg <= sdaIn ? ST_IDLE : ST_ACK;
              ackTo_reg <= ST_RDATA;
            end
          end
        endcase
      end
    end
  end

  // Reserved bits and reserved codes are kept as written
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      roleCfg_reg <= ROLE_CFG_RESET;
      rateCfg_reg <= RATE_CFG_RESET;
      clkSrc_reg <= CLOCK_SOURCE_CONFIG_RESET;
    end else if (ce && wrStb) begin
      unique case (ptr_reg)
        ROLE_CFG_ADDR: roleCfg_reg <= shift_reg;
        RATE_CFG_ADDR: rateCfg_reg <= shift_reg;
        CLOCK_SOURCE_CONFIG_ADDR: clkSrc_reg <= shift_reg;
        default: begin
        end
      endcase
    end
  end

  // Divider settings follow only codes that exist
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      activeRatio_reg <= RESET_FRAME_RATIO;
      dividerRatio <= RATE_CFG_RESET[3:0];
      dividerRate <= RATE_CFG_RESET[7:4];
    end else if (ce) begin
      if (rateCfg_reg.ratio <= RATIO_CODE_MAX) begin
        activeRatio_reg <= 12'(FRAME_RATIO[rateCfg_reg.ratio]);
        dividerRatio <= rateCfg_reg.ratio;
      end
      if (rateCfg_reg.rate <= RATE_CODE_MAX) begin
        dividerRate <= rateCfg_reg.rate;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bitClockOe <= 1'b0;
      frameSyncOe <= 1'b0;
      customDividers <= 1'b0;
      pllRunning <= 1'b1;
      rootFromReference <= 1'b0;
      programmedInUse <= 1'b0;
      family44 <= 1'b0;
      refIsMultiple <= 1'b0;
      refFreqKhz <= 16'h0000;
      refRatioValue <= 12'h000;
    end else if (ce) begin
      bitClockOe <= roleCfg_reg.controller;
      frameSyncOe <= roleCfg_reg.controller;
      customDividers <= roleCfg_reg.customClocks;
      pllRunning <= ~roleCfg_reg.customClocks & ~roleCfg_reg.autoPllOff;
      rootFromReference <= ~roleCfg_reg.controller & ~roleCfg_reg.customClocks &
        roleCfg_reg.autoPllOff & clkSrc_reg.rootFromRef;
      programmedInUse <= roleCfg_reg.controller | roleCfg_reg.customClocks;
      family44 <= roleCfg_reg.controller & roleCfg_reg.family44;
      refIsMultiple <= clkSrc_reg.refMultiple;
      refFreqKhz <= clkSrc_reg.refMultiple ? 16'h0000 : 16'(REF_KHZ[roleCfg_reg.refCode]);
      refRatioValue <= 12'(REF_RATIO[clkSrc_reg.refRatio]);
    end
  end

  // Monitor watches the line itself, whoever drives it
  assign monBclk = roleCfg_reg.controller ? bitClockOut : bitClockIn;
  assign monFrame = roleCfg_reg.controller ? frameSyncOut : frameSyncIn;

  apcm_clock_gen u_gen (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .run(roleCfg_reg.controller),
    .gate(roleCfg_reg.gate),
    .invert(clkSrc_reg.invertForFrame),
    .ratio(activeRatio_reg),
    .bclkOut(bitClockOut),
    .frameOut(frameSyncOut)
  );

  apcm_rate_monitor u_mon (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .bclk(monBclk),
    .frame(monFrame),
    .detected(detected)
  );
endmodule : apcm_top

// file: dv/apcm_top_props.sv
`timescale 1ns/1ps
module apcm_top_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic bitClockOut,
  input wire logic bitClockOe,
  input wire logic frameSyncOut,
  input wire logic frameSyncOe,
  input wire logic customDividers,
  input wire logic pllRunning,
  input wire logic rootFromReference,
  input wire logic programmedInUse,
  input wire logic family44,
  input wire logic [3:0] dividerRate,
  input wire logic [3:0] dividerRatio,
  input wire logic refIsMultiple,
  input wire logic [15:0] refFreqKhz
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_oe_pair; bitClockOe == frameSyncOe; endproperty
  property p_quiet; !bitClockOe |-> !bitClockOut && !frameSyncOut; endproperty
  property p_bclk_half; $rose(bitClockOut) |=> !bitClockOut; endproperty
  property p_frame_len; $rose(frameSyncOut) |-> frameSyncOut ##2 !frameSyncOut; endproperty
  property p_pll; pllRunning |-> !customDividers; endproperty
  property p_root; rootFromReference |-> !pllRunning && !bitClockOe; endproperty
  property p_prog; !programmedInUse |-> !customDividers && !bitClockOe; endproperty
  property p_family; family44 |-> bitClockOe; endproperty
  property p_ref_mult; refIsMultiple |-> refFreqKhz == 16'h0000; endproperty
  property p_codes; dividerRate <= 4'h8 && dividerRatio <= 4'hc; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("enable pair differs");
  a_quiet: assert property (p_quiet) else $error("clock out in target role");
  a_bclk_half: assert property (p_bclk_half) else $error("bit clock high too long");
  a_frame_len: assert property (p_frame_len) else $error("frame pulse length");
  a_pll: assert property (p_pll) else $error("pll on in custom mode");
  a_root: assert property (p_root) else $error("root source misuse");
  a_prog: assert property (p_prog) else $error("programmed use wrong");
  a_family: assert property (p_family) else $error("family outside controller");
  a_ref_mult: assert property (p_ref_mult) else $error("ref freq in multiple mode");
  a_codes: assert property (p_codes) else $error("reserved divider code");
  c_frame: cover property ($rose(frameSyncOut));
  c_root: cover property (rootFromReference);
  c_fam: cover property (family44 && bitClockOe);
endmodule : apcm_top_props

bind apcm_top apcm_top_props apcm_top_props_i (.clk(clk), .reset(reset),
  .bitClockOut(bitClockOut), .bitClockOe(bitClockOe), .frameSyncOut(frameSyncOut),
  .frameSyncOe(frameSyncOe), .customDividers(customDividers), .pllRunning(pllRunning),
  .rootFromReference(rootFromReference), .programmedInUse(programmedInUse),
  .family44(family44), .dividerRate(dividerRate), .dividerRatio(dividerRatio),
  .refIsMultiple(refIsMultiple), .refFreqKhz(refFreqKhz));

// file: dv/apcm_host_port.sv
`timescale 1ns/1ps
module apcm_host_port #(
  parameter int HALF = 13,
  parameter int RATIO = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  output logic bclk,
  output logic frame
);
  int hc;
  int bc;
  // Stopped host holds its clocks still
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hc <= 0;
      bc <= 0;
      bclk <= 1'b0;
      frame <= 1'b0;
    end else if (!run) begin
      hc <= 0;
      bc <= 0;
      bclk <= 1'b0;
      frame <= 1'b0;
    end else if (hc == HALF - 1) begin
      hc <= 0;
      bclk <= ~bclk;
      if (bclk) begin
        bc <= (bc == RATIO - 1) ? 0 : bc + 1;
        frame <= (bc == RATIO - 1);
      end
    end else begin
      hc <= hc + 1;
    end
  end
endmodule : apcm_host_port

// file: dv/apcm_top_tb_top.sv
`timescale 1ns/1ps
module apcm_top_tb_top;
  import apcm_pkg::*;
  logic clk = 0, reset = 1, ce = 1, scl = 1, sdaHost = 1, hostRun = 0;
  logic sdaIn, sdaOut, sdaOe, bitClockIn, bitClockOut, bitClockOe, hostBclk, hostFrame;
  logic frameSyncIn, frameSyncOut, frameSyncOe, customDividers, pllRunning;
  logic rootFromReference, programmedInUse, family44, refIsMultiple;
  logic [3:0] dividerRate, dividerRatio;
  logic [15:0] refFreqKhz;
  logic [11:0] refRatioValue;
  int error_cnt = 0, total_checks = 0, cycleCnt = 0;

  // Open-drain data line with pull-up; shared clock pins
  assign sdaIn = sdaHost & ~(sdaOe & ~sdaOut);
  assign bitClockIn = bitClockOe ? bitClockOut : hostBclk;
  assign frameSyncIn = frameSyncOe ? frameSyncOut : hostFrame;

  apcm_top apcm_top_i (.clk(clk), .reset(reset), .ce(ce), .scl(scl), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .bitClockIn(bitClockIn), .bitClockOut(bitClockOut),
    .bitClockOe(bitClockOe), .frameSyncIn(frameSyncIn), .frameSyncOut(frameSyncOut),
    .frameSyncOe(frameSyncOe), .customDividers(customDividers), .pllRunning(pllRunning),
    .rootFromReference(rootFromReference), .programmedInUse(programmedInUse),
    .family44(family44), .dividerRate(dividerRate), .dividerRatio(dividerRatio),
    .refIsMultiple(refIsMultiple), .refFreqKhz(refFreqKhz), .refRatioValue(refRatioValue));

  apcm_host_port #(.HALF(13), .RATIO(16)) apcm_host_port_i (.clk(clk), .reset(reset),
    .run(hostRun), .bclk(hostBclk), .frame(hostFrame));

  always #25 clk = ~clk;

  task end_sim;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  always @(posedge clk) begin
    cycleCnt++;
    if (cycleCnt == 80000) begin
      error_cnt++;
      end_sim;
    end
  end

  task tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tk

  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Reserved codes leave the divider on its last valid setting
  function logic [3:0] keep(input logic [3:0] old, input logic [3:0] nw, input logic [3:0] mx);
    return (nw <= mx) ? nw : old;
  endfunction : keep

  task bitx(input logic b, output logic r);
    sdaHost = b;
    tk(3);
    scl = 1;
    tk(2);
    r = sdaIn;
    tk(1);
    scl = 0;
    tk(1);
  endtask : bitx

  task start;
    sdaHost = 1;
    tk(3);
    scl = 1;
    tk(3);
    sdaHost = 0;
    tk(3);
    scl = 0;
    tk(2);
  endtask : start

  task stop;
    sdaHost = 0;
    tk(3);
    scl = 1;
    tk(3);
    sdaHost = 1;
    tk(3);
  endtask : stop

  task sendb(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
  endtask : sendb

  task wr(input logic [7:0] a, input logic [7:0] d);
    start;
    sendb({TARGET_ADDR_DEFAULT, 1'b0});
    sendb(a);
    sendb(d);
    stop;
  endtask : wr

  task rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    logic r;
    start;
    sendb({TARGET_ADDR_DEFAULT, 1'b0});
    sendb(a);
    start;
    sendb({TARGET_ADDR_DEFAULT, 1'b1});
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(1'b1, r);
    stop;
    chk(nm, {8'h00, e}, {8'h00, d});
  endtask : rchk

  // Bit clock rises between the second and third frame rises
  task frames(output int bc);
    int k;
    logic pf, pb;
    bc = 0;
    k = 0;
    pf = 1;
    pb = 1;
    for (int t = 0; t < 12000 && k < 3; t++) begin
      tk(1);
      if (frameSyncOut && !pf) k++;
      if (k == 2 && bitClockOut && !pb) bc++;
      pf = frameSyncOut;
      pb = bitClockOut;
    end
  endtask : frames

  initial begin
    int n;
    int codes [4];
    logic [7:0] v;
    logic [3:0] lastRate, lastRatio;
    void'($urandom(32'ha340b50b));
    codes = '{0, 3, 8, 11};
    tk(3);
    reset = 0;
    tk(2);
    rchk(ROLE_CFG_ADDR, 8'h02, "roleReset");
    rchk(RATE_CFG_ADDR, 8'h48, "rateReset");
    rchk(MON_STS_ADDR, 8'hff, "stsReset");
    rchk(CLOCK_SOURCE_CONFIG_ADDR, 8'h10, "srcReset");
    chk("refKhz", 16'd13000, refFreqKhz);
    chk("refRatio", 16'd384, {4'h0, refRatioValue});
    chk("pll", 16'h1, {15'h0, pllRunning});
    wr(MON_STS_ADDR, 8'h00);
    rchk(MON_STS_ADDR, 8'hff, "stsRo");
    rchk(8'h30, 8'h00, "unmapped");
    for (int c = 0; c < 8; c++) begin
      wr(ROLE_CFG_ADDR, {4'h8, c[0], c[2:0]});
      wr(CLOCK_SOURCE_CONFIG_ADDR, {1'b0, c[0], c[2:0], 3'b010});
      tk(2);
      chk("refKhz", c[0] ? 16'h0 : 16'(REF_KHZ[c]), refFreqKhz);
      chk("refRatio", 16'(REF_RATIO[c]), {4'h0, refRatioValue});
      chk("fam44", {15'h0, c[0]}, {15'h0, family44});
      chk("refMul", {15'h0, c[0]}, {15'h0, refIsMultiple});
      chk("oeCtl", 16'h1, {15'h0, frameSyncOe});
    end
    lastRate = 4'h4;
    lastRatio = 4'h8;
    for (n = 0; n < 12; n++) begin
      v = (n == 0) ? 8'h8c : (n == 1) ? 8'h9d : 8'($urandom);
      wr(RATE_CFG_ADDR, v);
      lastRate = keep(lastRate, v[7:4], RATE_CODE_MAX);
      lastRatio = keep(lastRatio, v[3:0], RATIO_CODE_MAX);
      tk(2);
      chk("divRate", {12'h0, lastRate}, {12'h0, dividerRate});
      chk("divRatio", {12'h0, lastRatio}, {12'h0, dividerRatio});
      rchk(RATE_CFG_ADDR, v, "rateRb");
    end
    for (int c = 0; c < 4; c++) begin
      // Both frame generation phases, plain and inverted bit clock
      wr(CLOCK_SOURCE_CONFIG_ADDR, {6'h04, c[0], 1'b0});
      wr(RATE_CFG_ADDR, {4'h4, 4'(codes[c])});
      frames(n);
      chk("bclkPerFrame", 16'(FRAME_RATIO[codes[c]]), 16'(n));
      rchk(MON_STS_ADDR, {4'hf, 4'(codes[c])}, "stsCtl");
    end
    wr(ROLE_CFG_ADDR, 8'h90);
    v = 8'h00;
    repeat (40) begin
      tk(1);
      v[0] = v[0] | bitClockOut | frameSyncOut;
    end
    chk("gated", 16'h0, {8'h00, v});
    wr(ROLE_CFG_ADDR, 8'h00);
    hostRun = 1;
    tk(1500);
    rchk(MON_STS_ADDR, 8'h40, "stsTgt");
    chk("progUse", 16'h0, {15'h0, programmedInUse});
    chk("oe", 16'h0, {15'h0, bitClockOe});
    wr(ROLE_CFG_ADDR, 8'h20);
    wr(CLOCK_SOURCE_CONFIG_ADDR, 8'h80);
    tk(2);
    chk("root", 16'h1, {15'h0, rootFromReference});
    chk("pllOff", 16'h0, {15'h0, pllRunning});
    wr(ROLE_CFG_ADDR, 8'h40);
    tk(2);
    chk("custom", 16'h1, {15'h0, customDividers});
    chk("progUse", 16'h1, {15'h0, programmedInUse});
    hostRun = 0;
    tk(4200);
    rchk(MON_STS_ADDR, 8'hff, "stsLost");
    // Second reset in mid-run must restore the programmed defaults
    reset = 1;
    tk(2);
    reset = 0;
    tk(2);
    rchk(ROLE_CFG_ADDR, 8'h02, "roleReset2");
    rchk(RATE_CFG_ADDR, 8'h48, "rateReset2");
    chk("divRatioReset", 16'h8, {12'h0, dividerRatio});
    end_sim;
  end
endmodule : apcm_top_tb_top
